// ==== pkg/serial_flash_pkg.sv ====
// Shared constants, carriers and state layout for the serial flash command core
package serial_flash_pkg;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_WRITE_UNLOCK   = 8'h06;
    localparam logic [7:0] OPC_PAGE_WRITE     = 8'h02;
    localparam logic [7:0] OPC_FOUR_K_WIPE    = 8'h20;
    localparam logic [7:0] OPC_BLOCK32_WIPE   = 8'h52;
    localparam logic [7:0] OPC_BLOCK64_WIPE   = 8'hd8;
    localparam logic [7:0] OPC_FULL_WIPE      = 8'hc7;
    localparam logic [7:0] OPC_FULL_WIPE_ALT  = 8'h60;
    localparam logic [7:0] OPC_FAST_READ      = 8'h0b;
    localparam logic [7:0] OPC_DUAL_OUT_READ  = 8'h3b;
    localparam logic [7:0] OPC_DUAL_IO_READ   = 8'hbb;

    // ----------------------------------------------------------------
    // Frame geometry and array layout
    // ----------------------------------------------------------------
    localparam logic [4:0]  BYTE_BITS         = 5'h08;
    localparam logic [4:0]  ADDR_BITS         = 5'h18;
    localparam logic [4:0]  DUMMY_SINGLE      = 5'h08;
    localparam logic [4:0]  DUMMY_DUAL_OUT    = 5'h08;
    localparam logic [4:0]  DUMMY_DUAL_IO     = 5'h04;
    localparam logic [15:0] PAGE_SPAN         = 16'h00ff;
    localparam logic [15:0] SECTOR_SPAN       = 16'h0fff;
    localparam logic [15:0] BLOCK32_SPAN      = 16'h7fff;
    localparam logic [15:0] BLOCK64_SPAN      = 16'hffff;
    localparam logic [15:0] TOP_ADDR          = 16'hffff;
    localparam logic [31:0] SECTOR_BYTES      = 32'h0000_1000;
    localparam logic [2:0]  LEVEL_WHOLE       = 3'h5;
    localparam logic [7:0]  ERASED_BYTE       = 8'hff;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_OUT, ST_PAGE_DATA, ST_TAIL, ST_IGNORE
    } frame_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_READ_SINGLE, OP_READ_DUAL_OUT, OP_READ_DUAL_IO, OP_PAGE_WRITE,
        OP_WIPE_4K, OP_WIPE_32K, OP_WIPE_64K, OP_WIPE_ALL
    } op_t;

    typedef enum logic [1:0] {
        CYC_IDLE, CYC_PROGRAM, CYC_ERASE
    } cyc_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic io0;   // bidir_serial_in_pin level
        logic io1;   // serial output pin level
    } spi_in_t;

    typedef struct packed {
        logic io0;
        logic io0_oe_n;
        logic io1;
        logic io1_oe_n;
    } spi_out_t;

    typedef struct packed {
        logic small_region_protect_bit;
        logic top_bottom_select_bit;
        logic protect_level_bit2;
        logic protect_level_bit1;
        logic protect_level_bit0;
    } protect_t;

    typedef struct packed {
        spi_in_t      s1;
        spi_in_t      s2;
        logic         sclk_d;
        logic         cs_d;
        frame_t       frame;
        op_t          op;
        logic [4:0]   bit_cnt;
        logic [23:0]  shift;
        logic [15:0]  addr;
        logic [7:0]   col;
        logic         got_byte;
        logic [7:0]   out_sh;
        spi_out_t     pins;
        logic         write_allowed_latch;
        cyc_t         cyc;
        logic [15:0]  base;
        logic [15:0]  walk;
        logic [15:0]  walk_end;
        logic [255:0] mask;
    } state_t;

endpackage

// ==== verilog/serial_flash_core.sv ====
// Serial flash command core: dual fast reads, page write and wipe cycles
module serial_flash_core (
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_n,
    // Serial port pins
    input  wire serial_flash_pkg::spi_in_t   i_spi,
    output      serial_flash_pkg::spi_out_t  o_spi,
    // Protection bits
    input  wire serial_flash_pkg::protect_t  i_protect,
    // Status
    output      logic                        o_cycle_in_progress_flag,
    output      logic                        o_write_allowed_latch
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] mem      [0:65535];
    logic [7:0] page_buf [0:255];

    serial_flash_pkg::state_t r_reg;
    serial_flash_pkg::state_t r_next;

    logic        mem_we;
    logic [15:0] mem_waddr;
    logic [7:0]  mem_wdata;
    logic        pb_we;
    logic [7:0]  pb_waddr;
    logic [7:0]  pb_wdata;

    // ----------------------------------------------------------------
    // Protection
    // ----------------------------------------------------------------
    // True when [lo,hi] overlaps the area the protection bits cover
    function automatic logic hits_protected(input serial_flash_pkg::protect_t p,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [2:0]  level;
        logic [15:0] span;
        logic [15:0] plo;
        logic [15:0] phi;
        level = {p.protect_level_bit2, p.protect_level_bit1, p.protect_level_bit0};
        span  = serial_flash_pkg::BLOCK64_SPAN;
        if (p.small_region_protect_bit && level < serial_flash_pkg::LEVEL_WHOLE && level != 3'h0) begin
            span = 16'((serial_flash_pkg::SECTOR_BYTES << (level - 3'h1)) - 32'h1);
        end
        if (p.top_bottom_select_bit) begin
            plo = 16'h0000;
            phi = span;
        end else begin
            plo = serial_flash_pkg::TOP_ADDR - span;
            phi = serial_flash_pkg::TOP_ADDR;
        end
        hits_protected = (level != 3'h0) && !(hi < plo || lo > phi);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic        rise;
    logic        fall;
    logic        busy;
    logic        wide;
    logic        dual_out;
    logic [23:0] sh_nx;
    logic [4:0]  cnt_nx;
    logic [7:0]  opc;
    logic [7:0]  byte_nx;
    logic [4:0]  dummy_len;
    logic [15:0] span;
    logic [15:0] prog_addr;

    always_comb begin
        r_next    = r_reg;
        mem_we    = 1'b0;
        pb_we     = 1'b0;
        pb_waddr  = r_reg.col;
        pb_wdata  = 8'h00;
        prog_addr = r_reg.base | r_reg.walk;
        mem_waddr = prog_addr;
        mem_wdata = serial_flash_pkg::ERASED_BYTE;
        opc       = 8'h00;
        byte_nx   = 8'h00;
        span      = serial_flash_pkg::BLOCK64_SPAN;

        // Pins pass two flops; only stage two feeds any logic
        r_next.s1     = i_spi;
        r_next.s2     = r_reg.s1;
        r_next.sclk_d = r_reg.s2.sclk;
        r_next.cs_d   = r_reg.s2.cs_n;

        rise     = r_reg.s2.sclk & ~r_reg.sclk_d;
        fall     = ~r_reg.s2.sclk & r_reg.sclk_d;
        busy     = (r_reg.cyc != serial_flash_pkg::CYC_IDLE);
        wide     = (r_reg.op == serial_flash_pkg::OP_READ_DUAL_IO);
        dual_out = (r_reg.op != serial_flash_pkg::OP_READ_SINGLE);
        sh_nx    = wide ? {r_reg.shift[21:0], r_reg.s2.io1, r_reg.s2.io0}
                        : {r_reg.shift[22:0], r_reg.s2.io0};
        cnt_nx   = r_reg.bit_cnt + (wide ? 5'h02 : 5'h01);
        case (r_reg.op)
            serial_flash_pkg::OP_READ_DUAL_IO:  dummy_len = serial_flash_pkg::DUMMY_DUAL_IO;
            serial_flash_pkg::OP_READ_DUAL_OUT: dummy_len = serial_flash_pkg::DUMMY_DUAL_OUT;
            default:                            dummy_len = serial_flash_pkg::DUMMY_SINGLE;
        endcase

        // ------------------------------------------------------------
        // Self-timed cycle: one byte per clock across the region
        // ------------------------------------------------------------
        case (r_reg.cyc)
            serial_flash_pkg::CYC_PROGRAM: begin
                mem_we    = r_reg.mask[r_reg.walk[7:0]];
                mem_wdata = mem[prog_addr] & page_buf[r_reg.walk[7:0]];
            end
            serial_flash_pkg::CYC_ERASE: begin
                mem_we    = 1'b1;
                mem_wdata = serial_flash_pkg::ERASED_BYTE;
            end
            default: ;
        endcase
        if (busy) begin
            if (r_reg.walk == r_reg.walk_end) begin
                r_next.cyc = serial_flash_pkg::CYC_IDLE;
            end else begin
                r_next.walk = r_reg.walk + 16'h0001;
            end
        end

        // ------------------------------------------------------------
        // Frame handling
        // ------------------------------------------------------------
        if (r_reg.s2.cs_n) begin
            r_next.frame         = serial_flash_pkg::ST_IDLE;
            r_next.pins.io0_oe_n = 1'b1;
            r_next.pins.io1_oe_n = 1'b1;
            if (!r_reg.cs_d) begin
                if (r_reg.frame == serial_flash_pkg::ST_PAGE_DATA && r_reg.bit_cnt == 5'h00
                        && r_reg.got_byte) begin
                    if (!hits_protected(i_protect, r_reg.addr & ~serial_flash_pkg::PAGE_SPAN,
                                        r_reg.addr | serial_flash_pkg::PAGE_SPAN)) begin
                        r_next.cyc      = serial_flash_pkg::CYC_PROGRAM;
                        r_next.base     = r_reg.addr & ~serial_flash_pkg::PAGE_SPAN;
                        r_next.walk     = 16'h0000;
                        r_next.walk_end = serial_flash_pkg::PAGE_SPAN;
                        r_next.write_allowed_latch      = 1'b0;
                    end
                end
                if (r_reg.frame == serial_flash_pkg::ST_TAIL) begin
                    case (r_reg.op)
                        serial_flash_pkg::OP_WIPE_4K:  span = serial_flash_pkg::SECTOR_SPAN;
                        serial_flash_pkg::OP_WIPE_32K: span = serial_flash_pkg::BLOCK32_SPAN;
                        default:                       span = serial_flash_pkg::BLOCK64_SPAN;
                    endcase
                    if ((r_reg.op == serial_flash_pkg::OP_WIPE_ALL)
                            ? !(i_protect.small_region_protect_bit || i_protect.protect_level_bit2
                                || i_protect.protect_level_bit1 || i_protect.protect_level_bit0)
                            : !hits_protected(i_protect, r_reg.addr & ~span, r_reg.addr | span)) begin
                        r_next.cyc      = serial_flash_pkg::CYC_ERASE;
                        r_next.base     = 16'h0000;
                        r_next.walk     = r_reg.addr & ~span;
                        r_next.walk_end = r_reg.addr | span;
                        r_next.write_allowed_latch      = 1'b0;
                    end
                end
            end
        end else if (r_reg.cs_d) begin
            r_next.frame   = serial_flash_pkg::ST_OPCODE;
            r_next.bit_cnt = 5'h00;
            r_next.op      = serial_flash_pkg::OP_NONE;
        end else if (rise) begin
            case (r_reg.frame)
                serial_flash_pkg::ST_OPCODE: begin
                    r_next.shift   = {r_reg.shift[22:0], r_reg.s2.io0};
                    r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                    if (r_reg.bit_cnt == serial_flash_pkg::BYTE_BITS - 5'h01) begin
                        opc            = {r_reg.shift[6:0], r_reg.s2.io0};
                        r_next.bit_cnt = 5'h00;
                        r_next.frame   = serial_flash_pkg::ST_IGNORE;
                        r_next.got_byte = 1'b0;
                        r_next.mask    = '0;
                        if (!busy) begin
                            case (opc)
                                serial_flash_pkg::OPC_WRITE_UNLOCK: r_next.write_allowed_latch = 1'b1;
                                serial_flash_pkg::OPC_FAST_READ: begin
                                    r_next.op    = serial_flash_pkg::OP_READ_SINGLE;
                                    r_next.frame = serial_flash_pkg::ST_ADDR;
                                end
                                serial_flash_pkg::OPC_DUAL_OUT_READ: begin
                                    r_next.op    = serial_flash_pkg::OP_READ_DUAL_OUT;
                                    r_next.frame = serial_flash_pkg::ST_ADDR;
                                end
                                // address arrives two bits a clock
                                serial_flash_pkg::OPC_DUAL_IO_READ: begin
                                    r_next.op    = serial_flash_pkg::OP_READ_DUAL_IO;
                                    r_next.frame = serial_flash_pkg::ST_ADDR;
                                end
                                default: begin
                                    if (r_reg.write_allowed_latch) begin
                                        r_next.frame = serial_flash_pkg::ST_ADDR;
                                        case (opc)
                                            serial_flash_pkg::OPC_PAGE_WRITE:
                                                r_next.op = serial_flash_pkg::OP_PAGE_WRITE;
                                            serial_flash_pkg::OPC_FOUR_K_WIPE:
                                                r_next.op = serial_flash_pkg::OP_WIPE_4K;
                                            serial_flash_pkg::OPC_BLOCK32_WIPE:
                                                r_next.op = serial_flash_pkg::OP_WIPE_32K;
                                            serial_flash_pkg::OPC_BLOCK64_WIPE:
                                                r_next.op = serial_flash_pkg::OP_WIPE_64K;
                                            serial_flash_pkg::OPC_FULL_WIPE,
                                            serial_flash_pkg::OPC_FULL_WIPE_ALT: begin
                                                r_next.op    = serial_flash_pkg::OP_WIPE_ALL;
                                                r_next.frame = serial_flash_pkg::ST_TAIL;
                                            end
                                            default: r_next.frame = serial_flash_pkg::ST_IGNORE;
                                        endcase
                                    end
                                end
                            endcase
                        end
                    end
                end
                serial_flash_pkg::ST_ADDR: begin
                    r_next.shift   = sh_nx;
                    r_next.bit_cnt = cnt_nx;
                    if (cnt_nx == serial_flash_pkg::ADDR_BITS) begin
                        r_next.addr    = sh_nx[15:0];
                        r_next.col     = sh_nx[7:0];
                        r_next.bit_cnt = 5'h00;
                        case (r_reg.op)
                            serial_flash_pkg::OP_PAGE_WRITE: r_next.frame = serial_flash_pkg::ST_PAGE_DATA;
                            serial_flash_pkg::OP_READ_SINGLE,
                            serial_flash_pkg::OP_READ_DUAL_OUT,
                            serial_flash_pkg::OP_READ_DUAL_IO: r_next.frame = serial_flash_pkg::ST_DUMMY;
                            default:                           r_next.frame = serial_flash_pkg::ST_TAIL;
                        endcase
                    end
                end
                serial_flash_pkg::ST_DUMMY: begin
                    r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                    if (r_reg.bit_cnt + 5'h01 == dummy_len) begin
                        r_next.bit_cnt = 5'h00;
                        r_next.frame   = serial_flash_pkg::ST_DATA_OUT;
                    end
                end
                serial_flash_pkg::ST_PAGE_DATA: begin
                    r_next.shift   = {r_reg.shift[22:0], r_reg.s2.io0};
                    r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                    if (r_reg.bit_cnt == serial_flash_pkg::BYTE_BITS - 5'h01) begin
                        pb_we               = 1'b1;
                        pb_wdata            = {r_reg.shift[6:0], r_reg.s2.io0};
                        r_next.mask[r_reg.col] = 1'b1;
                        r_next.col          = r_reg.col + 8'h01;
                        r_next.bit_cnt      = 5'h00;
                        r_next.got_byte     = 1'b1;
                    end
                end
                serial_flash_pkg::ST_TAIL: r_next.frame = serial_flash_pkg::ST_IGNORE;
                default: ;
            endcase
        end else if (fall && r_reg.frame == serial_flash_pkg::ST_DATA_OUT) begin
            // host has released the pins by now
            byte_nx = (r_reg.bit_cnt == 5'h00) ? mem[r_reg.addr] : r_reg.out_sh;
            r_next.pins.io1      = byte_nx[7];
            r_next.pins.io1_oe_n = 1'b0;
            if (dual_out) begin
                r_next.pins.io0      = byte_nx[6];
                r_next.pins.io0_oe_n = 1'b0;
                r_next.out_sh        = {byte_nx[5:0], 2'b00};
                r_next.bit_cnt       = r_reg.bit_cnt + 5'h02;
            end else begin
                r_next.out_sh  = {byte_nx[6:0], 1'b0};
                r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
            end
            if (r_next.bit_cnt == serial_flash_pkg::BYTE_BITS) begin
                r_next.bit_cnt = 5'h00;
                r_next.addr    = r_reg.addr + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg               <= '0;
            r_reg.s1.cs_n       <= 1'b1;
            r_reg.s2.cs_n       <= 1'b1;
            r_reg.cs_d          <= 1'b1;
            r_reg.pins.io0_oe_n <= 1'b1;
            r_reg.pins.io1_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Arrays carry no reset: a real array keeps its contents anyway
    always_ff @(posedge i_clock) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
        if (pb_we) begin
            page_buf[pb_waddr] <= pb_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_spi                    = r_reg.pins;
    assign o_cycle_in_progress_flag = busy;
    assign o_write_allowed_latch    = r_reg.write_allowed_latch;

endmodule // serial_flash_core

// ==== verif/sf_checker.sv ====
// Port assertions for the serial flash core
module sf_checker (
    // Clock and reset
    input wire logic                       i_clock,
    input wire logic                       i_rst_n,
    // Pins and status
    input wire serial_flash_pkg::spi_in_t  i_spi,
    input wire serial_flash_pkg::spi_out_t o_spi,
    input wire serial_flash_pkg::protect_t i_protect,
    input wire logic                       o_cycle_in_progress_flag,
    input wire logic                       o_write_allowed_latch
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic   bsy = o_cycle_in_progress_flag;
    wire logic   lat = o_write_allowed_latch;
    logic [16:0] busy_reg;
    always_ff @(posedge i_clock or negedge i_rst_n)
        if (!i_rst_n) busy_reg <= '0;
        else busy_reg <= bsy ? busy_reg + 17'h1 : '0;
    sequence s_idle; i_spi.cs_n [*5]; endsequence
    sequence s_busy; bsy [*4]; endsequence
    property p_idle; s_idle |-> o_spi.io0_oe_n && o_spi.io1_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("pins driven while deselected");
    property p_quiet; bsy |-> o_spi.io0_oe_n && o_spi.io1_oe_n; endproperty
    a_quiet: assert property (p_quiet) else $error("read served while busy");
    property p_start; $rose(bsy) |-> $past(lat, 4) ##[0:2] !lat; endproperty
    a_start: assert property (p_start) else $error("cycle without latch");
    property p_after_cs; $rose(bsy) |-> $past(i_spi.cs_n, 2) && i_spi.cs_n; endproperty
    a_after_cs: assert property (p_after_cs) else $error("cycle before select rise");
    property p_len; $fell(bsy) |-> busy_reg >= 17'd256; endproperty
    a_len: assert property (p_len) else $error("cycle too short");
    property p_set; $rose(lat) |-> !$past(i_spi.cs_n, 3) && !bsy; endproperty
    a_set: assert property (p_set) else $error("latch set outside frame");
    property p_hold; s_busy |-> !lat; endproperty
    a_hold: assert property (p_hold) else $error("latch kept in cycle");
    property p_pair; !o_spi.io0_oe_n |-> !o_spi.io1_oe_n; endproperty
    a_pair: assert property (p_pair) else $error("dual pin driven alone");
endmodule // sf_checker

bind serial_flash_core sf_checker sf_checker_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi(i_spi),
    .o_spi(o_spi), .i_protect(i_protect), .o_cycle_in_progress_flag(o_cycle_in_progress_flag),
    .o_write_allowed_latch(o_write_allowed_latch));

// ==== verif/host.sv ====
// SPI host model that drives the flash pins
module host (
    // Clock
    input  wire logic                       i_clock,
    // Pins
    input  wire serial_flash_pkg::spi_out_t i_dev,
    output      serial_flash_pkg::spi_in_t  o_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       cs_n = 1'b1, sclk = 1'b0, last = 1'b0;
    logic [1:0] en = 2'h0, hv = 2'h0;
    // Freed lines toggle, so a stale bit never passes for data
    always @(posedge i_clock) last <= ~last;
    assign o_pins = '{cs_n, sclk, !i_dev.io0_oe_n ? i_dev.io0 : en[0] ? hv[0] : last,
                      !i_dev.io1_oe_n ? i_dev.io1 : en[1] ? hv[1] : ~last};
    task automatic sel(input logic v);
        cs_n <= v;
        sclk <= 1'b0;
        repeat (6) @(posedge i_clock);
    endtask
    // pins freed a cycle before the first output fall
    task automatic xfer(input int n, input logic [31:0] v, input bit dual, input bit rd, output logic [31:0] r);
        r = '0;
        if (rd) en <= 2'h0;
        if (rd) @(posedge i_clock);
        for (int k = n - 1; k >= 0; k--) begin
            sclk <= 1'b0;
            en   <= rd ? 2'h0 : {dual, 1'b1};
            hv   <= dual ? v[2*k+:2] : {1'b0, v[k]};
            repeat (5) @(posedge i_clock);
            sclk <= 1'b1;
            r = dual ? {r[29:0], o_pins.io1, o_pins.io0} : {r[30:0], o_pins.io1};
            repeat (4) @(posedge i_clock);
        end
    endtask
endmodule // host

// ==== verif/tb_top.sv ====
// Self-checking bench for the serial flash command core
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] REF_OP [6] = '{8'hd8, 8'hc7, 8'h60, 8'h02, 8'h02, 8'h20};
    localparam int         REF_EX [6] = '{0, 0, 0, 8, 12, 1};
    logic                       i_clock = 1'b0, i_rst_n = 1'b0, flag, latch;
    serial_flash_pkg::protect_t i_protect = '0;
    serial_flash_pkg::spi_in_t  pins;
    serial_flash_pkg::spi_out_t dev;
    logic [7:0]                 mem [65536], pg [256];
    logic [31:0]                r;
    int error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'h9855, d;
    serial_flash_core serial_flash_core_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi(pins), .o_spi(dev),
        .i_protect(i_protect), .o_cycle_in_progress_flag(flag), .o_write_allowed_latch(latch));
    host host_i (.i_clock(i_clock), .i_dev(dev), .o_pins(pins));
    initial forever #25 i_clock = ~i_clock;
    always @(posedge i_clock) if (++cyc == 80000) begin
        error_cnt++;
        end_sim;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // opcode, address unless the opcode is 06, c7 or 60, then extra random bits
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int extra);
        host_i.sel(1'b0);
        host_i.xfer(8, op, 0, 0, r);
        if (op != 8'h06 && op != 8'hc7 && op != 8'h60) host_i.xfer(24, a, 0, 0, r);
        if (extra > 0) host_i.xfer(extra, $random(seed), 0, 0, r);
    endtask
    task automatic done(input logic run, input logic l);
        host_i.sel(1'b1);
        check(flag, run);
        for (int k = 0; k < 70000 && flag; k++) @(posedge i_clock);
        check(latch, l);
    endtask
    task automatic unlock;
        frame(8'h06, 0, 0);
        host_i.sel(1'b1);
        check(latch, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        frame(8'h02, 24'h000000, 8);
        done(0, 0);
        unlock;
        // four-k wipe with a read attempt while busy
        frame(8'h20, 24'h000123, 0);
        host_i.sel(1'b1);
        frame(8'h3b, 0, 8);
        host_i.xfer(4, 0, 1, 1, r);
        check({dev.io1_oe_n, dev.io0_oe_n}, 2'h3);
        done(1, 0);
        for (int k = 0; k < 4096; k++) mem[k] = 8'hff;
        unlock;
        // block wipe, upper address byte ignored
        frame(8'h52, 24'h5a8abc, 0);
        done(1, 0);
        for (int k = 32768; k < 65536; k++) mem[k] = 8'hff;
        for (int i = 0; i < 2; i++) begin
            unlock;
            frame(8'h02, 24'h33fffe, 0);
            for (int k = 0; k < 256; k++) pg[k] = 8'hff;
            // wrap in page, last byte per column kept
            for (int k = 0; k < 3 + 255 * i; k++) begin
                d = $random(seed);
                host_i.xfer(8, d, 0, 0, r);
                pg[(254 + k) % 256] = d[7:0];
            end
            for (int k = 0; k < 256; k++) mem[16'hff00 + k] &= pg[k];
            done(1, 0);
        end
        unlock;
        for (int k = 0; k < 6; k++) begin
            // Random map: the first four always cover the whole array
            d = $random(seed);
            i_protect <= k < 4 ? {1'b0, d[3], d[2:0] | 3'h1} : d[4:0];
            frame(REF_OP[k], 24'h00ff00, REF_EX[k]);
            done(0, 1);
        end
        // single fast read leaves the bidir pin released
        frame(8'h0b, 24'h00ff02, 8);
        host_i.xfer(16, 0, 0, 1, r);
        check(dev.io0_oe_n, 1'b1);
        host_i.sel(1'b1);
        check(r[15:0], {mem[16'hff02], mem[16'hff03]});
        // dual output read, eight dummy clocks
        frame(8'h3b, 24'h00ff00, 8);
        host_i.xfer(16, 0, 1, 1, r);
        host_i.sel(1'b1);
        check(r, {mem[16'hff00], mem[16'hff01], mem[16'hff02], mem[16'hff03]});
        // address in pairs, four dummy clocks
        host_i.sel(1'b0);
        host_i.xfer(8, 8'hbb, 0, 0, r);
        host_i.xfer(12, 32'h00fffe, 1, 0, r);
        host_i.xfer(4, $random(seed), 1, 0, r);
        host_i.xfer(16, 0, 1, 1, r);
        host_i.sel(1'b1);
        check(r, {mem[16'hfffe], mem[16'hffff], mem[0], mem[1]});
        end_sim;
    end
endmodule // tb_top
